// [design/tcu_timer.sv]
// Function
// RQ1: Enable resets low, written only with gate.
// RQ2: Write gate is not stored, reads zero.
// RQ3: Interrupt enable gives request on limit match.
// RQ4: Terminal flag sets on limit, software clears.
// RQ5: Free run repeats; otherwise enable clears.
// RQ6: Sixteen bit readable count per timer.
// RQ7: Software clears count before enabling timer.
// RQ8: Software setup order; channel two last.
// RQ9: Count advances once per selected event.
// RQ10: Pin edges synchronised; only rising transitions count.
// RQ11: Pin clock, chain bits select event source.
// RQ12: Channel two ticks only; chain needs it running.
// RQ13: Increment, compare, reset in one service.
// RQ14: Limit zero means 65536 counts.
// RQ15: Limit found by equality only, wraps.
// RQ16: Limit writes allowed anytime without disturbance.
// RQ17: Single mode uses limit A; channel two only.
// RQ18: Two limit mode alternates A then B.
// RQ19: Level gate counts ticks while pin high.
// RQ20: Restart edge zeroes count; waits first edge.
// RQ21: Restart keeps active limit indicator unchanged.
// RQ22: Software writes zero to reserved bits.
// RQ23: Indicator reads one while limit B used.
// RQ24: Single mode output pulses low one clock.
// RQ25: Two limit output low while B used.
// RQ26: Two limit mode interrupts at both limits.
// RQ27: Four clock frame serves channels, one idle.
// RQ28: Register accesses land in the idle clock.
`timescale 1ns/1ns
`default_nettype none

module tcu_timer (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [tcu_pkg::TCU_ADDR_W-1:0] paddr,
    input  wire logic [tcu_pkg::TCU_DATA_W-1:0] pwdata,
    output logic      [tcu_pkg::TCU_DATA_W-1:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [tcu_pkg::TCU_PIN_CHS-1:0] timer_in,
    output logic      [tcu_pkg::TCU_PIN_CHS-1:0] timer_out,
    output logic      [tcu_pkg::TCU_CHANS-1:0]   irq_req
);
    import tcu_pkg::*;

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    tcu_slot_type                slot_q;
    logic [TCU_CHANS-1:0]        serve;
    logic [TCU_PIN_CHS-1:0]      pin_level;
    logic [TCU_PIN_CHS-1:0]      pin_edge;
    logic [TCU_PIN_CHS-1:0]      pin_ack;
    logic                        chain_hit_q;
    logic                        acc_done;
    logic                        wr_done;
    logic                        addr_ok;
    logic [15:0]                 rd_word;
    logic [15:0]                 cnt_q     [TCU_CHANS];
    logic [15:0]                 lim_a_q   [TCU_CHANS];
    logic [15:0]                 lim_b_q   [TCU_CHANS];
    logic [15:0]                 ctrl_rd   [TCU_CHANS];
    logic [TCU_CHANS-1:0]        match;
    logic [TCU_CHANS-1:0]        act_b_q;

    // ------------------------------------------------------------------
    // Counter element sequencer.
    // ------------------------------------------------------------------

    // The frame walks channel 0, 1, 2 and then one idle clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_q <= TCU_SLOT_CH0;
        end else begin
            case (slot_q)
                TCU_SLOT_CH0:  slot_q <= TCU_SLOT_CH1; // RQ27
                TCU_SLOT_CH1:  slot_q <= TCU_SLOT_CH2;
                TCU_SLOT_CH2:  slot_q <= TCU_SLOT_IDLE;
                TCU_SLOT_IDLE: slot_q <= TCU_SLOT_CH0;
                default:       slot_q <= TCU_SLOT_CH0;
            endcase
        end
    end

    // One-hot slot bits name the channel served in this clock.
    assign serve   = slot_q[TCU_CHANS-1:0];
    assign pin_ack = serve[TCU_PIN_CHS-1:0];

    // ------------------------------------------------------------------
    // Input pin conditioning.
    // ------------------------------------------------------------------
    tcu_input_sync #(
        .WIDTH (TCU_PIN_CHS)
    ) u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin       (timer_in),
        .ack       (pin_ack),
        .level     (pin_level),
        .edge_pend (pin_edge)
    );

    // ------------------------------------------------------------------
    // APB slave.
    // ------------------------------------------------------------------

    // The access completes at the edge that closes the idle clock.
    assign acc_done = psel && penable && pready;
    assign wr_done  = acc_done && pwrite;

    // Ready rises for the idle clock only, so no service clashes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= TCU_RST_BIT;
        end else begin
            pready <= psel && penable && !pready
                      && (slot_q == TCU_SLOT_CH2); // RQ28
        end
    end

    // Address decode for the eleven mapped words.
    always_comb begin
        addr_ok = 1'b1;
        rd_word = TCU_RST_WORD;
        case (paddr)
            TCU_OFF_CTRL0:  rd_word = ctrl_rd[0];
            TCU_OFF_CTRL1:  rd_word = ctrl_rd[1];
            TCU_OFF_CTRL2:  rd_word = ctrl_rd[2];
            TCU_OFF_COUNT0: rd_word = cnt_q[0]; // RQ6
            TCU_OFF_COUNT1: rd_word = cnt_q[1];
            TCU_OFF_COUNT2: rd_word = cnt_q[2];
            TCU_OFF_LIMA0:  rd_word = lim_a_q[0];
            TCU_OFF_LIMB0:  rd_word = lim_b_q[0];
            TCU_OFF_LIMA1:  rd_word = lim_a_q[1];
            TCU_OFF_LIMB1:  rd_word = lim_b_q[1];
            TCU_OFF_LIMA2:  rd_word = lim_a_q[2];
            default:        addr_ok = 1'b0;
        endcase
    end

    // Read data and error are captured together with ready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= TCU_RST_RDATA;
            pslverr <= TCU_RST_BIT;
        end else if (psel && penable && !pready
                     && (slot_q == TCU_SLOT_CH2)) begin
            prdata  <= {16'h0000, rd_word};
            pslverr <= !addr_ok;
        end else begin
            prdata  <= TCU_RST_RDATA;
            pslverr <= TCU_RST_BIT;
        end
    end

    // ------------------------------------------------------------------
    // Chain pulse from channel 2.
    // ------------------------------------------------------------------

    // Channel 2 timeout is held for one frame for channels 0 and 1.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain_hit_q <= TCU_RST_BIT;
        end else if (serve[2]) begin
            chain_hit_q <= match[2]; // RQ12
        end
    end

    // ------------------------------------------------------------------
    // Channels.
    // ------------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < TCU_CHANS; c++) begin : g_ch
            localparam bit HAS_PIN = (c < TCU_PIN_CHS);
            localparam logic [5:0] OFF_CTRL  = TCU_OFF_CTRL0  + 6'(4 * c);
            localparam logic [5:0] OFF_COUNT = TCU_OFF_COUNT0 + 6'(4 * c);
            localparam logic [5:0] OFF_LIMA  = TCU_OFF_LIMA0  + 6'(8 * c);
            localparam logic [5:0] OFF_LIMB  = TCU_OFF_LIMB0  + 6'(8 * c);

            logic        en_q;
            logic        irq_en_q;
            logic        term_q;
            logic        free_q;
            logic        two_q;
            logic        pclk_sel_q;
            logic        chain_q;
            logic        rtg_q;
            logic        armed_q;
            logic        gate;
            logic        edge_now;
            logic        level_now;
            logic        tick;
            logic        restart;
            logic        active;
            logic        seq_end;
            logic [15:0] lim;
            logic [15:0] inc;
            logic        ctrl_wr;

            assign ctrl_wr   = wr_done && (paddr == OFF_CTRL);
            assign edge_now  = HAS_PIN ? pin_edge[c % TCU_PIN_CHS]  : 1'b0;
            assign level_now = HAS_PIN ? pin_level[c % TCU_PIN_CHS] : 1'b0;

            // Event source selection and pin gating.
            always_comb begin
                if (pclk_sel_q) begin
                    tick = edge_now; // RQ11
                end else if (chain_q) begin
                    tick = chain_hit_q; // RQ11
                end else begin
                    tick = 1'b1; // RQ9
                end
                if (pclk_sel_q) begin
                    gate = 1'b1;
                end else if (rtg_q) begin
                    gate = armed_q; // RQ20
                end else if (HAS_PIN) begin
                    gate = level_now; // RQ19
                end else begin
                    gate = 1'b1; // RQ12
                end
            end

            // Restart edges only act with internal clocking.
            assign restart = !pclk_sel_q && rtg_q && edge_now; // RQ20
            assign active  = serve[c] && en_q && gate && tick;
            assign lim     = act_b_q[c] ? lim_b_q[c] : lim_a_q[c]; // RQ18
            assign inc     = cnt_q[c] + 16'h0001; // RQ15
            assign match[c] = active && !restart && (inc == lim); // RQ14
            assign seq_end = !two_q || act_b_q[c]; // RQ5

            // Control bits; only the gate lets a write reach enable.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    en_q       <= TCU_RST_BIT; // RQ1
                    irq_en_q   <= TCU_RST_BIT;
                    free_q     <= TCU_RST_BIT;
                    two_q      <= TCU_RST_BIT;
                    pclk_sel_q <= TCU_RST_BIT;
                    chain_q    <= TCU_RST_BIT;
                    rtg_q      <= TCU_RST_BIT;
                end else if (ctrl_wr) begin
                    if (pwdata[TCU_B_WRITE_GATE]) begin
                        en_q <= pwdata[TCU_B_ENABLE]; // RQ1
                    end
                    irq_en_q   <= pwdata[TCU_B_IRQ_EN];
                    free_q     <= pwdata[TCU_B_FREE_RUN];
                    two_q      <= HAS_PIN && pwdata[TCU_B_TWO_LIMIT]; // RQ17
                    pclk_sel_q <= HAS_PIN && pwdata[TCU_B_PIN_CLOCK];
                    chain_q    <= HAS_PIN && pwdata[TCU_B_CHAIN];
                    rtg_q      <= HAS_PIN && pwdata[TCU_B_RESTART];
                end else if (match[c] && seq_end && !free_q) begin
                    en_q <= 1'b0; // RQ5
                end
            end

            // Terminal flag: hardware sets, a control write loads the TCU_B_TERM_COUNT bit.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    term_q <= TCU_RST_BIT;
                end else if (match[c]) begin
                    term_q <= 1'b1; // RQ4
                end else if (ctrl_wr) begin
                    term_q <= pwdata[TCU_B_TERM_COUNT];
                end
            end

            // Restart mode waits for a first edge after enabling.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    armed_q <= TCU_RST_BIT;
                end else if (ctrl_wr && pwdata[TCU_B_WRITE_GATE]) begin
                    armed_q <= 1'b0; // RQ20
                end else if (serve[c] && en_q && restart) begin
                    armed_q <= 1'b1;
                end
            end

            // Count: increment, compare and reset in the one slot.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q[c] <= TCU_RST_WORD;
                end else if (wr_done && (paddr == OFF_COUNT)) begin
                    cnt_q[c] <= pwdata[15:0];
                end else if (serve[c] && en_q && restart) begin
                    cnt_q[c] <= TCU_RST_WORD; // RQ20
                end else if (match[c]) begin
                    cnt_q[c] <= TCU_RST_WORD; // RQ13
                end else if (active) begin
                    cnt_q[c] <= inc; // RQ9
                end
            end

            // Limits may be rewritten while running.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lim_a_q[c] <= TCU_RST_WORD;
                    lim_b_q[c] <= TCU_RST_WORD;
                end else begin
                    if (wr_done && (paddr == OFF_LIMA)) begin
                        lim_a_q[c] <= pwdata[15:0]; // RQ16
                    end
                    if (HAS_PIN && wr_done && (paddr == OFF_LIMB)) begin
                        lim_b_q[c] <= pwdata[15:0]; // RQ16
                    end
                end
            end

            // In two limit mode the active limit toggles on each limit, single mode holds it at A; restarts leave it.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    act_b_q[c] <= TCU_RST_BIT;
                end else if (match[c] && two_q) begin
                    act_b_q[c] <= !act_b_q[c]; // RQ21
                end else if (!two_q) begin
                    act_b_q[c] <= 1'b0; // RQ17
                end
            end

            // Interrupt request is a one clock pulse per limit.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_req[c] <= TCU_RST_BIT;
                end else begin
                    irq_req[c] <= match[c] && irq_en_q; // RQ3 RQ26
                end
            end

            // Output pin: pulse in single mode, level in two limit mode.
            if (HAS_PIN) begin : g_out
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        timer_out[c] <= TCU_RST_PIN;
                    end else if (two_q) begin
                        timer_out[c] <= !(act_b_q[c] ^ match[c]); // RQ25
                    end else begin
                        timer_out[c] <= !match[c]; // RQ24
                    end
                end
            end

            // Control read view; the write gate always reads zero.
            always_comb begin
                ctrl_rd[c]                   = TCU_RST_WORD;
                ctrl_rd[c][TCU_B_ENABLE]     = en_q;
                ctrl_rd[c][TCU_B_WRITE_GATE] = 1'b0; // RQ2
                ctrl_rd[c][TCU_B_IRQ_EN]     = irq_en_q;
                ctrl_rd[c][TCU_B_ACT_LIMIT]  = act_b_q[c]; // RQ23
                ctrl_rd[c][TCU_B_TERM_COUNT] = term_q;
                ctrl_rd[c][TCU_B_RESTART]    = rtg_q;
                ctrl_rd[c][TCU_B_CHAIN]      = chain_q;
                ctrl_rd[c][TCU_B_PIN_CLOCK]  = pclk_sel_q;
                ctrl_rd[c][TCU_B_TWO_LIMIT]  = two_q;
                ctrl_rd[c][TCU_B_FREE_RUN]   = free_q;
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [common/tcu_pkg.sv]
package tcu_pkg;

    // ------------------------------------------------------------------
    // Sizes.
    // ------------------------------------------------------------------
    localparam int unsigned TCU_CNT_W   = 16;
    localparam int unsigned TCU_ADDR_W  = 6;
    localparam int unsigned TCU_DATA_W  = 32;
    localparam int unsigned TCU_CHANS   = 3;
    localparam int unsigned TCU_PIN_CHS = 2;

    // ------------------------------------------------------------------
    // Register byte offsets on the APB side.
    // ------------------------------------------------------------------
    localparam logic [5:0] TCU_OFF_CTRL0   = 6'h00;
    localparam logic [5:0] TCU_OFF_CTRL1   = 6'h04;
    localparam logic [5:0] TCU_OFF_CTRL2   = 6'h08;
    localparam logic [5:0] TCU_OFF_COUNT0  = 6'h0C;
    localparam logic [5:0] TCU_OFF_COUNT1  = 6'h10;
    localparam logic [5:0] TCU_OFF_COUNT2  = 6'h14;
    localparam logic [5:0] TCU_OFF_LIMA0   = 6'h18;
    localparam logic [5:0] TCU_OFF_LIMB0   = 6'h1C;
    localparam logic [5:0] TCU_OFF_LIMA1   = 6'h20;
    localparam logic [5:0] TCU_OFF_LIMB1   = 6'h24;
    localparam logic [5:0] TCU_OFF_LIMA2   = 6'h28;

    // ------------------------------------------------------------------
    // Control register field positions.
    // ------------------------------------------------------------------
    localparam int unsigned TCU_B_FREE_RUN   = 0;
    localparam int unsigned TCU_B_TWO_LIMIT  = 1;
    localparam int unsigned TCU_B_PIN_CLOCK  = 2;
    localparam int unsigned TCU_B_CHAIN      = 3;
    localparam int unsigned TCU_B_RESTART    = 4;
    localparam int unsigned TCU_B_TERM_COUNT = 5;
    localparam int unsigned TCU_B_ACT_LIMIT  = 12;
    localparam int unsigned TCU_B_IRQ_EN     = 13;
    localparam int unsigned TCU_B_WRITE_GATE = 14;
    localparam int unsigned TCU_B_ENABLE     = 15;

    // ------------------------------------------------------------------
    // Values after reset.
    // ------------------------------------------------------------------
    localparam logic        TCU_RST_BIT   = 1'b0;
    localparam logic [15:0] TCU_RST_WORD  = 16'h0000;
    localparam logic        TCU_RST_PIN   = 1'b1;
    localparam logic [31:0] TCU_RST_RDATA = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Counter element frame: one clock per channel, fourth clock idle.
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TCU_SLOT_CH0  = 4'b0001,
        TCU_SLOT_CH1  = 4'b0010,
        TCU_SLOT_CH2  = 4'b0100,
        TCU_SLOT_IDLE = 4'b1000
    } tcu_slot_type;

endpackage

// [design/tcu_input_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module tcu_input_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin,
    input  wire logic [WIDTH-1:0] ack,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] edge_pend
);
    import tcu_pkg::*;

    // ------------------------------------------------------------------
    // Per pin synchroniser, level stage and rising edge catcher.
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            logic meta_q;
            logic sync_q;
            logic prev_q;

            // Two flip-flops bring the pin into the clock domain.
            // All stages reset to the idle high level, so that a pin
            // resting high gives no false edge after reset.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_q <= TCU_RST_PIN;
                    sync_q <= TCU_RST_PIN;
                end else begin
                    meta_q <= pin[i];
                    sync_q <= meta_q;
                end
            end

            // A third stage gives the level and the previous sample.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    prev_q <= TCU_RST_PIN;
                end else begin
                    prev_q <= sync_q;
                end
            end

            // A low then high transition is held until the slot takes it.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    edge_pend[i] <= TCU_RST_BIT;
                end else if (sync_q && !prev_q) begin
                    edge_pend[i] <= 1'b1; // RQ10
                end else if (ack[i]) begin
                    edge_pend[i] <= 1'b0;
                end
            end

            assign level[i] = prev_q;
        end
    endgenerate

endmodule

`default_nettype wire

// [tb/tcu_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module tcu_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [5:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rdata;
    logic        err;
    logic        hung;
    // Bus idles with no request pending.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 6'h00;
        pwdata = 32'h0;
    end
    // One transfer, held until ready is seen at a rising edge.
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        hung = pready !== 1'b1;
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// [tb/tcu_timer_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module tcu_timer_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [5:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  irq_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answers come as lone pulses inside an access phase.
    property p_rdy; pready |-> psel && penable ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready misplaced");
    property p_wait; $rose(penable) && psel |-> ##[1:4] pready; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("stray data");
    property p_err; pready && paddr > 6'h28 |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error");
    // Control reads never show the gate bit or upper bits.
    property p_gate; pready && !pwrite && paddr < 6'h0C
        |-> !prdata[14] && prdata[31:16] == 16'h0; endproperty
    a_gate: assert property (p_gate) else $error("gate read");
    // Each channel is serviced once per four-clock frame.
    property p_i0; irq_req[0] |=> !irq_req[0] [*3]; endproperty
    a_i0: assert property (p_i0) else $error("irq0 spacing");
    property p_i1; irq_req[1] |=> !irq_req[1] [*3]; endproperty
    a_i1: assert property (p_i1) else $error("irq1 spacing");
    property p_i2; irq_req[2] |=> !irq_req[2] [*3]; endproperty
    a_i2: assert property (p_i2) else $error("irq2 spacing");
    property p_one; irq_req != 3'b000 |-> $onehot(irq_req); endproperty
    a_one: assert property (p_one) else $error("irq overlap");
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tcu_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [5:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  timer_in = 2'b11;
    logic [1:0]  timer_out;
    logic [2:0]  irq_req;
    logic [15:0] lim;
    int          k;
    int          n_fail = 0;
    int          checks_done = 0;
    // Clock at 250 MHz.
    always #2 pclk = ~pclk;
    tcu_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_in(timer_in),
        .timer_out(timer_out), .irq_req(irq_req));
    tcu_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // Report verdict and stop.
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Compare one word.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Register access with a hang guard.
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        host.xfer(w, a, d);
        if (host.hung) begin
            n_fail++;
            close_out();
        end
    endtask
    // Control word with the write gate set.
    function automatic logic [31:0] cw(input logic [15:0] b);
        return {16'h0, b | 16'h4000};
    endfunction
    // Wait for a channel request under a bound.
    task automatic wait_irq(input int ch, input int bound);
        int n;
        n = 0;
        while (irq_req[ch] !== 1'b1 && n < bound) begin
            @(posedge pclk);
            n++;
        end
        if (n >= bound) begin
            n_fail++;
            close_out();
        end
    endtask
    // Main sequence.
    initial begin
        void'($urandom(76091));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        acc(0, TCU_OFF_CTRL0, 0);
        chk(host.rdata, 32'h0);
        acc(0, 6'h2C, 0);
        chk(host.err, 1'b1);
        acc(1, TCU_OFF_CTRL0, 32'h8000);
        acc(0, TCU_OFF_CTRL0, 0);
        chk(host.rdata, 32'h0);
        $display("test gate done");
        lim = 16'($urandom_range(6, 2));
        acc(1, TCU_OFF_COUNT0, 0);
        acc(1, TCU_OFF_LIMA0, {16'h0, lim});
        acc(1, TCU_OFF_CTRL0, cw(16'hA000));
        wait_irq(0, 8 * lim + 40);
        chk(timer_out[0], 1'b0);
        acc(0, TCU_OFF_CTRL0, 0);
        chk(host.rdata, 32'h2020);
        acc(0, TCU_OFF_COUNT0, 0);
        chk(host.rdata, 32'h0);
        acc(1, TCU_OFF_CTRL0, 0);
        acc(0, TCU_OFF_CTRL0, 0);
        chk(host.rdata, 32'h0);
        $display("test single done");
        timer_in[1] <= 1'b0;
        acc(1, TCU_OFF_COUNT1, 0);
        acc(1, TCU_OFF_CTRL1, cw(16'h8001));
        repeat (40) @(posedge pclk);
        acc(0, TCU_OFF_COUNT1, 0);
        chk(host.rdata, 32'h0);
        acc(1, TCU_OFF_CTRL1, cw(16'h0000));
        acc(1, TCU_OFF_COUNT1, 0);
        acc(1, TCU_OFF_CTRL1, cw(16'h8004));
        k = $urandom_range(5, 2);
        repeat (k) begin
            timer_in[1] <= 1'b1;
            repeat (8) @(posedge pclk);
            timer_in[1] <= 1'b0;
            repeat (8) @(posedge pclk);
        end
        acc(0, TCU_OFF_COUNT1, 0);
        chk(host.rdata, k);
        $display("test pin clock done");
        acc(1, TCU_OFF_COUNT0, 0);
        acc(1, TCU_OFF_LIMA0, 2);
        acc(1, TCU_OFF_LIMB0, 32'h40);
        acc(1, TCU_OFF_CTRL0, cw(16'hA003));
        wait_irq(0, 60);
        @(posedge pclk);
        chk(timer_out[0], 1'b0);
        acc(0, TCU_OFF_CTRL0, 0);
        chk(host.rdata & 32'h1000, 32'h1000);
        $display("test two limit done");
        timer_in[1] <= 1'b1;
        acc(1, TCU_OFF_COUNT1, 0);
        acc(1, TCU_OFF_LIMA1, 2);
        acc(1, TCU_OFF_CTRL1, cw(16'hA008));
        acc(1, TCU_OFF_COUNT2, 0);
        acc(1, TCU_OFF_LIMA2, 3);
        acc(1, TCU_OFF_CTRL2, cw(16'hA001));
        wait_irq(2, 40);
        wait_irq(1, 80);
        chk(timer_out[1], 1'b0);
        $display("test chain done");
        close_out();
    end
endmodule
bind tcu_timer tcu_timer_chk chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_req(irq_req));
`default_nettype wire
